// ---- gpb_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----
// far side logic on the expansion header
// ----
module gpb_far_model
   import gpb_pkg::*;
(
   input wire logic clock,
   input wire logic [4:0] pin_o,
   input wire logic [4:0] pin_oe,
   input wire logic [4:0] ext_pins,
   output logic [4:0] pin_i,
   input wire logic [7:0] bus_o,
   input wire logic bus_oe,
   input wire logic [7:0] rd_data,
   output logic [7:0] bus_i,
   output logic [7:0] cap_byte
);
   logic [7:0] last_q = 8'h00;
   // wire level of each single pin, external circuit drives released pins
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_pins);
   // byte offered while read strobe is low, floating bus keeps changing
   assign bus_i = bus_oe ? bus_o : ((pin_oe[3] && !pin_o[3]) ? rd_data : ~last_q);
   // last bus level, so a released bus never looks stable
   always @(posedge clock) begin
      last_q <= bus_i;
   end
   // capture written byte on rising write strobe
   always @(posedge pin_o[4]) begin
      if (pin_oe[4]) begin
         cap_byte <= bus_i;
      end
   end
endmodule
`default_nettype wire

// ---- gpb_pkg.sv ----
`include "gpb_regs.svh"
package gpb_pkg;
   // strobe sequencer states
   typedef enum logic [1:0] {
      GPB_IDLE  = 2'b00,
      GPB_SETUP = 2'b01,
      GPB_PULSE = 2'b10,
      GPB_HOLD  = 2'b11
   } gpb_seq_st_t;

   // sequencer state
   typedef struct packed {
      gpb_seq_st_t st;
      logic wr;
      logic [`GPB_CNT_W-1:0] cnt;
   } gpb_seq_t;

   // port state
   typedef struct packed {
      logic [`GPB_NUM_SINGLE-1:0] pin_out;
      logic [`GPB_NUM_SINGLE-1:0] pin_oe;
      logic [`GPB_NUM_SINGLE-1:0] pin_in;
      logic [`GPB_BUS_W-1:0] bus_out;
      logic bus_oe;
      logic [`GPB_BUS_W-1:0] bus_in;
      logic busy;
      logic done;
      logic frame_mark;
      logic battery_low;
      logic power_on;
   } gpb_port_t;
endpackage

// ---- gpb_port.sv ----
// Functional notes
// - the port offers five single pins and an eight pin byte bus, thirteen pins in all.
// - after reset every single pin and every bus pin is an input with its driver off.
// - single pins are steered bit by bit while the bus is read and written as one byte.
// - each single pin has its own direction bit selecting input or output.
// - a bus transfer is framed by a low strobe of at least 50 ns, pin four reads, pin five writes.
// - a read strobe latches the byte present on the bus pins into the bus input data.
// - a write strobe drives and latches the output byte onto the bus pins for the far side.
// - pin one is plain i/o or, read as input, a frame start indicator.
// - pin two is plain i/o or, read as input, a battery low flag.
// - pin three driven high enables card and display power, driven low disables it.
// - with pin three set as input an external circuit decides the power level.
`timescale 1ns/10ps
`default_nettype none
module gpb_port
   import gpb_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`GPB_NUM_SINGLE-1:0] pin_dir,
   input wire logic [`GPB_NUM_SINGLE-1:0] pin_out_val,
   output logic [`GPB_NUM_SINGLE-1:0] pin_in_val,
   input wire logic [`GPB_NUM_SINGLE-1:0] pin_i,
   output logic [`GPB_NUM_SINGLE-1:0] pin_o,
   output logic [`GPB_NUM_SINGLE-1:0] pin_oe,
   input wire logic bus_dir_out,
   input wire logic bus_rd_req,
   input wire logic bus_wr_req,
   input wire logic [`GPB_BUS_W-1:0] bus_wr_byte,
   output logic [`GPB_BUS_W-1:0] bus_rd_byte,
   output logic bus_busy,
   output logic bus_done,
   input wire logic [`GPB_BUS_W-1:0] byte_bus_pins_i,
   output logic [`GPB_BUS_W-1:0] byte_bus_pins_o,
   output logic byte_bus_pins_oe,
   output logic frame_mark,
   output logic battery_low,
   output logic peripheral_power_on
);
   gpb_seq_if sq ();
   gpb_port_t q, d;
   logic transfer;
   logic start_req;

   // ------------------------------------------------------------
   // strobe sequencer
   // ------------------------------------------------------------
   gpb_strobe_seq u_seq (
      .clock(clock),
      .rst_n(rst_n),
      .sq(sq.seq)
   );

   // request gating, write wins when both arrive together
   assign start_req = (bus_rd_req | bus_wr_req) & (sq.st == GPB_IDLE);
   assign sq.start = start_req;
   assign sq.is_write = bus_wr_req;
   assign transfer = (sq.st != GPB_IDLE);

   // ------------------------------------------------------------
   // next state of pins, bus and status
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      // per pin direction and value
      for (int i = 0; i < `GPB_NUM_SINGLE; i++) begin
         d.pin_oe[i] = pin_dir[i];
         d.pin_out[i] = pin_out_val[i];
      end
      // strobe pin takes over during a transfer
      if (transfer) begin
         if (sq.wr) begin
            d.pin_oe[`GPB_PIN_WR] = 1'b1;
            d.pin_out[`GPB_PIN_WR] = (sq.st != GPB_PULSE);
         end else begin
            d.pin_oe[`GPB_PIN_RD] = 1'b1;
            d.pin_out[`GPB_PIN_RD] = (sq.st != GPB_PULSE);
         end
      end
      d.pin_in = pin_i;
      // latch output byte on a write request
      if (start_req && bus_wr_req) begin
         d.bus_out = bus_wr_byte;
      end
      // drive for writes, release for inputs and reads
      d.bus_oe = transfer ? sq.wr : bus_dir_out;
      // capture bus at the end of the read pulse
      if (sq.st == GPB_HOLD && !sq.wr) begin
         d.bus_in = byte_bus_pins_i;
      end
      d.busy = transfer | start_req;
      d.done = (sq.st == GPB_HOLD);
      // alternate pin meanings, only while the pin is an input
      d.frame_mark = !pin_dir[`GPB_PIN_FRAME] & pin_i[`GPB_PIN_FRAME];
      d.battery_low = !pin_dir[`GPB_PIN_BATT] & pin_i[`GPB_PIN_BATT];
      // own drive or external circuit
      d.power_on = pin_dir[`GPB_PIN_POWER] ? pin_out_val[`GPB_PIN_POWER]
                                           : pin_i[`GPB_PIN_POWER];
   end

   // ------------------------------------------------------------
   // state register, all inputs after reset
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q.pin_out <= `GPB_RST_SINGLE;
         q.pin_oe <= `GPB_RST_SINGLE;
         q.pin_in <= `GPB_RST_SINGLE;
         q.bus_out <= `GPB_RST_BYTE;
         q.bus_oe <= 1'b0;
         q.bus_in <= `GPB_RST_BYTE;
         q.busy <= 1'b0;
         q.done <= 1'b0;
         q.frame_mark <= 1'b0;
         q.battery_low <= 1'b0;
         q.power_on <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the register
   assign pin_o = q.pin_out;
   assign pin_oe = q.pin_oe;
   assign pin_in_val = q.pin_in;
   assign byte_bus_pins_o = q.bus_out;
   assign byte_bus_pins_oe = q.bus_oe;
   assign bus_rd_byte = q.bus_in;
   assign bus_busy = q.busy;
   assign bus_done = q.done;
   assign frame_mark = q.frame_mark;
   assign battery_low = q.battery_low;
   assign peripheral_power_on = q.power_on;

   // ------------------------------------------------------------
   // helper: length of the current low strobe
   // ------------------------------------------------------------
   localparam int STROBE_CYC_I = `GPB_STROBE_CYC;
   logic [`GPB_CNT_W-1:0] low_cnt_q;
   logic strobe_low;
   assign strobe_low = (q.pin_oe[`GPB_PIN_RD] & !q.pin_out[`GPB_PIN_RD])
                     | (q.pin_oe[`GPB_PIN_WR] & !q.pin_out[`GPB_PIN_WR]);

   // count cycles the strobe is low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q <= `GPB_RST_CNT;
      end else if (strobe_low && transfer) begin
         low_cnt_q <= low_cnt_q + `GPB_CNT_W'(1);
      end else begin
         low_cnt_q <= `GPB_RST_CNT;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_strobe_width_min: assert property (
      ($fell(strobe_low) && low_cnt_q != `GPB_RST_CNT) |-> (low_cnt_q == STROBE_CYC_I))
      else $error("strobe low time differs from minimum");
   a_done_latency: assert property (
      start_req |-> ##16 bus_done)
      else $error("done not sixteen edges after request");
   a_rd_bus_release: assert property (
      (transfer && q.pin_oe[`GPB_PIN_RD] && !q.pin_out[`GPB_PIN_RD]) |-> !byte_bus_pins_oe)
      else $error("bus driven during read strobe");
   a_wr_bus_drive: assert property (
      (transfer && q.pin_oe[`GPB_PIN_WR] && !q.pin_out[`GPB_PIN_WR])
         |-> byte_bus_pins_oe && $stable(byte_bus_pins_o))
      else $error("write byte not held during strobe");
   a_wr_byte_latch: assert property (
      (start_req && bus_wr_req) |=> (byte_bus_pins_o == $past(bus_wr_byte)))
      else $error("write byte not latched");
   a_rd_capture_val: assert property (
      (bus_done && !sq.wr) |-> (bus_rd_byte == $past(byte_bus_pins_i)))
      else $error("read byte not captured");
   a_idle_bus_dir: assert property (
      (!transfer && $past(!transfer) && $past(rst_n))
         |-> (byte_bus_pins_oe == $past(bus_dir_out)))
      else $error("bus driver not following direction");
   a_pin_dir_follow: assert property (
      (!transfer && $past(!transfer) && $past(rst_n)) |-> (pin_oe == $past(pin_dir)))
      else $error("pin enable not following direction");
   a_frame_mark_in: assert property (
      !pin_dir[`GPB_PIN_FRAME] |=> (frame_mark == $past(pin_i[`GPB_PIN_FRAME])))
      else $error("frame mark not following pin");
   a_battery_flag_in: assert property (
      pin_dir[`GPB_PIN_BATT] |=> !battery_low)
      else $error("battery flag set while pin is output");
   a_power_level_src: assert property (
      pin_dir[`GPB_PIN_POWER]
         |=> (peripheral_power_on == $past(pin_out_val[`GPB_PIN_POWER])))
      else $error("power enable not following driven level");
   a_power_external: assert property (
      !pin_dir[`GPB_PIN_POWER]
         |=> (peripheral_power_on == $past(pin_i[`GPB_PIN_POWER])) && !pin_oe[`GPB_PIN_POWER])
      else $error("external power level not followed");

   c_read_done: cover property (start_req && !bus_wr_req ##16 bus_done);
   c_write_done: cover property (start_req && bus_wr_req ##16 bus_done);
   c_back_to_back: cover property (bus_done ##1 start_req);
   c_power_ext: cover property (!pin_dir[`GPB_PIN_POWER] && peripheral_power_on);
endmodule
`default_nettype wire

// ---- gpb_regs.svh ----
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH
// ------------------------------------------------------------
// pin counts and positions
// ------------------------------------------------------------
`define GPB_NUM_SINGLE 5
`define GPB_BUS_W 8
`define GPB_PIN_FRAME 0
`define GPB_PIN_BATT 1
`define GPB_PIN_POWER 2
`define GPB_PIN_RD 3
`define GPB_PIN_WR 4
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define GPB_CLK_PERIOD_NS 4
`define GPB_STROBE_MIN_NS 50
// least time rounds up to whole cycles
`define GPB_STROBE_CYC (((`GPB_STROBE_MIN_NS) + (`GPB_CLK_PERIOD_NS) - 1) / (`GPB_CLK_PERIOD_NS))
`define GPB_CNT_W 5
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define GPB_RST_SINGLE 5'h00
`define GPB_RST_BYTE 8'h00
`define GPB_RST_CNT 5'h00
`endif

// ---- gpb_seq_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// link between port logic and strobe sequencer
interface gpb_seq_if;
   import gpb_pkg::*;
   logic start;
   logic is_write;
   gpb_seq_st_t st;
   logic wr;
   modport ctl (output start, output is_write, input st, input wr);
   modport seq (input start, input is_write, output st, output wr);
endinterface
`default_nettype wire

// ---- gpb_strobe_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
module gpb_strobe_seq
   import gpb_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   gpb_seq_if.seq sq
);
   localparam logic [`GPB_CNT_W-1:0] LAST_CNT = `GPB_CNT_W'(`GPB_STROBE_CYC - 1);
   gpb_seq_t q, d;

   // ------------------------------------------------------------
   // sequence: setup, low pulse, hold
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      case (q.st)
         GPB_IDLE: begin
            if (sq.start) begin
               d.st = GPB_SETUP;
               d.wr = sq.is_write;
               d.cnt = `GPB_RST_CNT;
            end
         end
         GPB_SETUP: begin
            d.st = GPB_PULSE;
            d.cnt = `GPB_RST_CNT;
         end
         GPB_PULSE: begin
            d.cnt = q.cnt + `GPB_CNT_W'(1);
            if (q.cnt == LAST_CNT) begin // pulse length
               d.st = GPB_HOLD;
            end
         end
         GPB_HOLD: begin
            d.st = GPB_IDLE;
         end
         default: begin
            d.st = GPB_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: GPB_IDLE, wr: 1'b0, cnt: `GPB_RST_CNT};
      end else begin
         q <= d;
      end
   end

   assign sq.st = q.st;
   assign sq.wr = q.wr;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // pulse phase ends thirteen cycles after it opens
   a_seq_pulse_span: assert property (@(posedge clock) disable iff (!rst_n)
      (q.st == GPB_SETUP) |=> (q.st == GPB_PULSE) ##13 (q.st == GPB_HOLD))
      else $error("strobe phase not thirteen cycles");
   // pulse phase never leaves before its last count
   a_seq_pulse_stay: assert property (@(posedge clock) disable iff (!rst_n)
      (q.st == GPB_PULSE && q.cnt != LAST_CNT) |=> (q.st == GPB_PULSE))
      else $error("strobe phase left early");
endmodule
`default_nettype wire

// ---- gpio_port_with_strobed_byte_bus_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module gpio_port_with_strobed_byte_bus_test;
   import gpb_pkg::*;
   typedef struct packed {logic wr; logic [7:0] v;} gpb_exp_t;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] pin_dir = 5'h00;
   logic [4:0] pin_out_val = 5'h00;
   logic [4:0] ext_pins = 5'h18;
   logic [4:0] pin_i, pin_o, pin_oe;
   logic bus_dir_out = 1'b0;
   logic bus_rd_req = 1'b0;
   logic bus_wr_req = 1'b0;
   logic [7:0] bus_wr_byte = 8'h00;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] bus_rd_byte, bus_i, bus_o, cap_byte;
   logic bus_busy, bus_done, bus_oe, frame_mark, battery_low, power_on;
   logic [7:0] r = 8'h34;
   gpb_exp_t q[$];
   gpb_exp_t e;
   int error_cnt = 0;
   int checks_done = 0;
   int lowc = 0;
   // ----
   // clock, design and far side
   // ----
   always #2 clock = ~clock;
   gpb_port i_dut (.clock(clock), .rst_n(rst_n), .pin_dir(pin_dir), .pin_out_val(pin_out_val),
      .pin_in_val(), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .bus_dir_out(bus_dir_out),
      .bus_rd_req(bus_rd_req), .bus_wr_req(bus_wr_req), .bus_wr_byte(bus_wr_byte),
      .bus_rd_byte(bus_rd_byte), .bus_busy(bus_busy), .bus_done(bus_done),
      .byte_bus_pins_i(bus_i), .byte_bus_pins_o(bus_o), .byte_bus_pins_oe(bus_oe),
      .frame_mark(frame_mark), .battery_low(battery_low), .peripheral_power_on(power_on));
   gpb_far_model i_far (.clock(clock), .pin_o(pin_o), .pin_oe(pin_oe), .ext_pins(ext_pins),
      .pin_i(pin_i), .bus_o(bus_o), .bus_oe(bus_oe), .rd_data(rd_data), .bus_i(bus_i),
      .cap_byte(cap_byte));
   // ----
   // helpers
   // ----
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one strobed transfer, expected result noted first
   task automatic xfer(input logic wr, input logic [7:0] v);
      int n;
      n = 0;
      q.push_back('{wr, v});
      @(posedge clock);
      bus_wr_byte <= v;
      rd_data <= v;
      bus_wr_req <= wr;
      bus_rd_req <= !wr;
      @(posedge clock);
      bus_wr_req <= 1'b0;
      bus_rd_req <= 1'b0;
      while (bus_done !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      chk(n < 40, "no done");
   endtask
   // ----
   // output watcher: results, strobe width, bus release
   // ----
   always @(posedge clock) begin
      if (!rst_n) begin
         lowc = 0;
      end else begin
         if (bus_busy === 1'b1 && pin_oe[3] && !pin_o[3]) begin
            chk(bus_oe === 1'b0, "bus driven in read");
         end
         if (bus_busy === 1'b1 && ((pin_oe[3] && !pin_o[3]) || (pin_oe[4] && !pin_o[4]))) begin
            lowc++;
         end else if (lowc != 0) begin
            chk(lowc == `GPB_STROBE_CYC && lowc * 4 >= 50, "strobe width");
            lowc = 0;
         end
         if (bus_done === 1'b1) begin
            chk(q.size() > 0, "unexpected done");
            e = q.pop_front();
            if (e.wr) begin
               chk(cap_byte === e.v, "write byte");
            end else begin
               chk(bus_rd_byte === e.v, "read byte");
            end
         end
      end
   end
   // ----
   // tests
   // ----
   initial begin
      repeat (8) @(posedge clock);
      chk(pin_oe === 5'h00 && bus_oe === 1'b0, "reset not inputs");
      rst_n <= 1'b1;
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         r = lfsr(r);
         pin_dir <= r[4:0];
         pin_out_val <= r[7:3];
         @(posedge clock);
         @(negedge clock);
         chk(pin_oe === r[4:0] && pin_o === r[7:3], "single pins");
      end
      $display("test single done");
      @(posedge clock);
      pin_dir <= 5'h00;
      ext_pins <= {2'h3, r[2:0]};
      repeat (3) @(negedge clock);
      chk(frame_mark === r[0], "frame mark");
      chk(battery_low === r[1], "battery low");
      chk(power_on === r[2], "external power");
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         pin_dir <= 5'h07;
         pin_out_val <= {2'h0, i[0], 2'h3};
         repeat (2) @(negedge clock);
         chk(power_on === i[0] && frame_mark === 1'b0, "power out");
      end
      $display("test status done");
      @(posedge clock);
      pin_dir <= 5'h00;
      for (int i = 0; i < 6; i++) begin
         r = lfsr(r);
         @(posedge clock);
         bus_dir_out <= r[1];
         xfer(i[0], lfsr(r));
      end
      xfer(1'b1, 8'ha5);
      @(posedge clock);
      bus_dir_out <= 1'b1;
      repeat (2) @(negedge clock);
      chk(bus_oe === 1'b1 && bus_o === 8'ha5, "idle drive");
      chk(q.size() == 0, "missing results");
      $display("test transfer done");
      @(posedge clock);
      rst_n <= 1'b0;
      @(negedge clock);
      chk(pin_oe === 5'h00 && bus_oe === 1'b0 && power_on === 1'b0, "mid reset");
      @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(negedge clock);
      chk(bus_oe === 1'b1 && bus_o === 8'h00 && pin_oe === 5'h00, "after rereset");
      $display("test rereset done");
      wrap_up();
   end
   // watchdog
   initial begin
      #80000;
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire
